// ### core/eipu_line_in.sv
// per-line input stage: pin synchroniser and optional clockless edge catcher
`timescale 1ns/1ps
`default_nettype none

module eipu_line_in
  import eipu_pkg::*;
#(
  parameter bit ASYNC_EDGE = 1'b0
) (
  input wire logic i_mclk, // system i/o clock
  input wire logic i_rst_n, // asynchronous reset, active low
  input wire logic i_pin, // pin level after the input buffer gate
  input wire logic i_rise_sel, // edge polarity for the catcher, 1 = rising
  output logic o_level, // filtered pin level
  output logic o_async_evt // one-cycle pulse per caught edge
);

  logic [2:0] sync_r;
  logic level_r;

  // three flops; the level moves only once the second and third agree
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_r <= RST_SYNC;
      level_r <= 1'b1;
    end else begin
      sync_r <= {sync_r[1:0], i_pin};
      if (sync_r[1] == sync_r[2]) begin
        level_r <= sync_r[2];
      end
    end
  end

  assign o_level = level_r;

  if (ASYNC_EDGE) begin : g_async
    logic edge_clk;
    logic tgl_r;
    logic [2:0] tsync_r;
    logic seen_r;

    // the pin itself clocks a toggle, so a short pulse is kept with no clock running
    assign edge_clk = i_pin ^ ~i_rise_sel;

    always_ff @(posedge edge_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        tgl_r <= 1'b0;
      end else begin
        tgl_r <= ~tgl_r;
      end
    end

    // toggle crosses into the clock domain; each settled change is one event
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        tsync_r <= 3'h0;
        seen_r <= 1'b0;
        o_async_evt <= 1'b0;
      end else begin
        tsync_r <= {tsync_r[1:0], tgl_r};
        o_async_evt <= (tsync_r[1] == tsync_r[2]) && (tsync_r[2] != seen_r);
        if (tsync_r[1] == tsync_r[2]) begin
          seen_r <= tsync_r[2];
        end
      end
    end
  end else begin : g_sync
    assign o_async_evt = 1'b0;
  end

endmodule // eipu_line_in

`default_nettype wire

// ### core/eipu_pkg.sv
// shared constants and types of the external pin interrupt unit
`default_nettype none

package eipu_pkg;

  // line counts: low lines are caught without a clock, high lines are sampled
  localparam int NUM_LINES = 8;
  localparam int ASYNC_LINES = 4;
  localparam int SENSE_W = 2;

  // apb word offsets (byte addresses)
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_SENSE_LOW = 12'h000;
  localparam logic [11:0] ADDR_SENSE_HIGH = 12'h004;
  localparam logic [11:0] ADDR_ENABLE_MASK = 12'h008;
  localparam logic [11:0] ADDR_PENDING = 12'h00C;
  localparam logic [11:0] ADDR_PIN_LEVEL = 12'h010;

  // values after reset; zero sense selects low level on every line
  localparam logic [7:0] RST_SENSE_LOW = 8'h00;
  localparam logic [7:0] RST_SENSE_HIGH = 8'h00;
  localparam logic [7:0] RST_ENABLE_MASK = 8'h00;
  localparam logic [7:0] RST_PENDING = 8'h00;
  localparam logic [2:0] RST_SYNC = 3'h7;
  localparam logic [3:0] RST_BUF_EN = 4'hF;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // field layout: line n uses bits (n mod 4)*2+1 and (n mod 4)*2
  localparam int SENSE_FIELDS_PER_REG = 4;

  // timing: clock period and the least pulse that the low lines must catch
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_INT_NS = 50;
  localparam int INT_PULSE_CYC = ((T_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                                 ((T_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // watchdog oscillator samples a low level must survive before wake-up
  localparam int WAKE_SAMPLES = 2;

  // sense selection codes
  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_ANY  = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } eipu_sense_e;

endpackage

`default_nettype wire

// ### core/eipu_top.sv
// external pin interrupt unit: eight lines, sense control, mask, pending flags, apb slave
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - low lines request only when global enable and the line mask bit are set
// - low lines: 00 low level, 01 reserved, 10 falling edge, 11 rising edge
// - low-line edges are caught without a clock; pulses over about 50 ns register
// - enabled low-level line keeps requesting while its pin stays low
// - high lines sample the pin; pulses over two clock periods are caught
// - high lines: 00 low level, 01 any change, 10 falling, 11 rising between samples
// - eight mask bits, reset to zero; line enabled only with global enable too
// - pin activity triggers even when the pin is driven by the chip itself
// - an edge or change that triggers a request sets the line's pending flag
// - pending with both enables vectors the cpu; handler entry clears the flag
// - writing one clears a pending flag, writing zero leaves it
// - a line in level mode always reads its pending flag as zero
// - sleeping with low lines disabled turns their input buffers off
// - low-line sense resets to low level and is hidden in legacy mode
// - sense registers hold four two-bit fields, line n at bits 2n+1..2n mod 4
// - high-line edges need the i/o clock; levels and low-line edges do not
// - level wake needs two watchdog samples; a vanished level gives no wake and no request
module eipu_top
  import eipu_pkg::*;
(
  input wire logic i_mclk, // system i/o clock, 10 MHz
  input wire logic i_rst_n, // asynchronous reset, active low
  // apb slave
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb access phase
  input wire logic i_pwrite, // apb direction, 1 = write
  input wire logic [eipu_pkg::ADDR_W-1:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error for unmapped address
  // pins and cpu side
  input wire logic [eipu_pkg::NUM_LINES-1:0] i_ext_request_pins, // external request pins
  input wire logic i_global_int_en, // global flag of the cpu status register
  input wire logic [eipu_pkg::NUM_LINES-1:0] i_handler_ack, // pulse: handler of line n entered
  input wire logic i_sleep, // cpu is entering or in sleep
  input wire logic i_io_clk_run, // i/o clock running (not halted by sleep)
  input wire logic i_wdt_tick, // one-cycle pulse per watchdog oscillator period
  input wire logic i_legacy_mode, // legacy compatibility mode strap
  output logic [eipu_pkg::NUM_LINES-1:0] o_irq_req, // request per line to the cpu
  output logic o_wake, // one-cycle wake-up pulse
  output logic [eipu_pkg::ASYNC_LINES-1:0] o_pin_buf_en // input buffer enable, low lines
);

  import eipu_pkg::*;

  // register file
  logic [7:0] sense_low_r;
  logic [7:0] sense_high_r;
  logic [7:0] line_enable_mask_r;
  logic [7:0] line_pending_flags_r;
  logic [7:0] line_pending_flags_nxt;

  // bus answer
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  // outputs
  logic [NUM_LINES-1:0] irq_r;
  logic [NUM_LINES-1:0] irq_nxt;
  logic wake_r;
  logic wake_nxt;
  logic [ASYNC_LINES-1:0] buf_en_r;

  // per-line datapath
  logic [NUM_LINES-1:0] pin_gated;
  logic [NUM_LINES-1:0] level;
  logic [NUM_LINES-1:0] level_prev_r;
  logic [NUM_LINES-1:0] async_evt;
  logic [NUM_LINES-1:0] line_evt;
  logic [NUM_LINES-1:0] is_level;
  logic [NUM_LINES-1:0] line_on;
  logic [NUM_LINES-1:0] low_seen_r;
  logic [NUM_LINES-1:0] low_seen_nxt;
  logic [NUM_LINES-1:0] level_wake;
  logic [NUM_LINES-1:0][SENSE_W-1:0] sense_w;

  // address decode
  logic setup_w;
  logic hit_sense_low;
  logic hit_sense_high;
  logic hit_mask;
  logic hit_pending;
  logic hit_pin_level;
  logic hit_any;
  logic wr_commit;
  logic [31:0] rdata_w;
  logic [7:0] sense_low_view;
  logic [7:0] w1c_mask;

  // apb decode; every register sits in one aligned word, upper bits read zero
  assign setup_w = i_psel & ~i_penable;
  assign hit_sense_low = (i_paddr == ADDR_SENSE_LOW);
  assign hit_sense_high = (i_paddr == ADDR_SENSE_HIGH);
  assign hit_mask = (i_paddr == ADDR_ENABLE_MASK);
  assign hit_pending = (i_paddr == ADDR_PENDING);
  assign hit_pin_level = (i_paddr == ADDR_PIN_LEVEL);
  assign hit_any = hit_sense_low | hit_sense_high | hit_mask | hit_pending | hit_pin_level;
  // writes land only at the edge where the access phase sees ready, never on an error
  assign wr_commit = i_psel & i_penable & pready_r & i_pwrite & hit_any;

  // legacy mode hides the low-line sense register: reads zero, writes dropped
  assign sense_low_view = i_legacy_mode ? 8'h00 : sense_low_r;

  assign rdata_w = hit_sense_low ? {24'h00_0000, sense_low_view} :
                   hit_sense_high ? {24'h00_0000, sense_high_r} :
                   hit_mask ? {24'h00_0000, line_enable_mask_r} :
                   hit_pending ? {24'h00_0000, line_pending_flags_r} :
                   hit_pin_level ? {24'h00_0000, level} :
                   32'h0000_0000;

  // write-one-to-clear strobe for the pending flags
  assign w1c_mask = (wr_commit && hit_pending) ? i_pwdata[7:0] : 8'h00;

  // bus answer: zero wait states, ready and data both launched from the setup cycle
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready_r <= 1'b0;
      prdata_r <= RST_RDATA;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup_w;
      pslverr_r <= setup_w & ~hit_any;
      if (setup_w) begin
        prdata_r <= i_pwrite ? 32'h0000_0000 : rdata_w;
      end
    end
  end

  // control registers written by software
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sense_low_r <= RST_SENSE_LOW;
      sense_high_r <= RST_SENSE_HIGH;
      line_enable_mask_r <= RST_ENABLE_MASK;
    end else if (wr_commit) begin
      if (hit_sense_low && !i_legacy_mode) begin
        sense_low_r <= i_pwdata[7:0];
      end
      if (hit_sense_high) begin
        sense_high_r <= i_pwdata[7:0];
      end
      if (hit_mask) begin
        line_enable_mask_r <= i_pwdata[7:0];
      end
    end
  end

  // per-line input stage, field select and event classification
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
    localparam int FB = (i % SENSE_FIELDS_PER_REG) * SENSE_W;
    logic fall_w;
    logic rise_w;

    // two-bit field of line i, modulo four within its register
    assign sense_w[i] = (i < ASYNC_LINES) ? sense_low_r[FB +: SENSE_W] : sense_high_r[FB +: SENSE_W];
    assign is_level[i] = (sense_w[i] == SENSE_LOW);
    assign line_on[i] = i_global_int_en & line_enable_mask_r[i];

    // the pin is watched whatever its direction, so driving it raises a request
    if (i < ASYNC_LINES) begin : g_gate
      assign pin_gated[i] = i_ext_request_pins[i] & buf_en_r[i];
    end else begin : g_open
      assign pin_gated[i] = i_ext_request_pins[i];
    end

    eipu_line_in #(
      .ASYNC_EDGE(i < ASYNC_LINES)
    ) u_line_in (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_pin(pin_gated[i]),
      .i_rise_sel(sense_w[i][0]),
      .o_level(level[i]),
      .o_async_evt(async_evt[i])
    );

    // consecutive settled samples of the synchronised pin
    assign fall_w = level_prev_r[i] & ~level[i];
    assign rise_w = ~level_prev_r[i] & level[i];

    if (i < ASYNC_LINES) begin : g_async_evt
      // reserved and level codes raise no edge event
      assign line_evt[i] = async_evt[i] & sense_w[i][1];
    end else begin : g_sync_evt
      // sampled edges only count while the i/o clock runs
      assign line_evt[i] = i_io_clk_run & (
                           ((sense_w[i] == SENSE_ANY) & (fall_w | rise_w)) |
                           ((sense_w[i] == SENSE_FALL) & fall_w) |
                           ((sense_w[i] == SENSE_RISE) & rise_w));
    end

    // flag: the hardware set wins over any clear in the same cycle
    assign line_pending_flags_nxt[i] = is_level[i] ? 1'b0 :
                                       line_evt[i] ? 1'b1 :
                                       (w1c_mask[i] | i_handler_ack[i]) ? 1'b0 :
                                       line_pending_flags_r[i];

    // level lines request live from the pin, edge lines from their flag
    assign irq_nxt[i] = line_on[i] & (is_level[i] ? ~level[i] : line_pending_flags_r[i]);

    // level wake: low on two consecutive watchdog samples; no flag, no latched request
    assign low_seen_nxt[i] = i_wdt_tick ? (is_level[i] & line_on[i] & ~level[i]) : low_seen_r[i];
    assign level_wake[i] = i_wdt_tick & low_seen_r[i] & is_level[i] & line_on[i] & ~level[i];
  end

  // wake on a caught low-line edge or a confirmed low level; both work with the i/o clock halted
  assign wake_nxt = |(line_on[ASYNC_LINES-1:0] & line_evt[ASYNC_LINES-1:0]) | (|level_wake);

  // flags, sample history and wake tracking
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      line_pending_flags_r <= RST_PENDING;
      level_prev_r <= {NUM_LINES{1'b1}};
      low_seen_r <= {NUM_LINES{1'b0}};
    end else begin
      line_pending_flags_r <= line_pending_flags_nxt;
      level_prev_r <= level;
      low_seen_r <= low_seen_nxt;
    end
  end

  // registered outputs; buffers of disabled low lines switch off in sleep
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_r <= {NUM_LINES{1'b0}};
      wake_r <= 1'b0;
      buf_en_r <= RST_BUF_EN;
    end else begin
      irq_r <= irq_nxt;
      wake_r <= wake_nxt;
      buf_en_r <= ~({ASYNC_LINES{i_sleep}} & ~line_enable_mask_r[ASYNC_LINES-1:0]);
    end
  end

  // the gate forces a disabled buffer low, so a high pin may set the flag here as a side effect
  assign o_pin_buf_en = buf_en_r;
  assign o_irq_req = irq_r;
  assign o_wake = wake_r;
  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;

endmodule // eipu_top

`default_nettype wire

// ### verification/eipu_pins_model.sv
// board-side driver of the external request pins
`timescale 1ns/1ps
`default_nettype none

module eipu_pins_model (
  input wire logic i_mclk, // bench clock, used to stretch pulses
  input wire logic [7:0] i_pull_low, // lines the board pulls low
  output logic [7:0] o_pins // pin levels, pulled up when released
);
  logic [7:0] low_r = 8'h00;

  // a pulled line stays low one extra clock, so no pulse is shorter than a period
  always @(posedge i_mclk) begin
    low_r <= i_pull_low;
  end

  // released lines return to the pull-up level
  assign o_pins = ~(i_pull_low | low_r);
endmodule // eipu_pins_model

`default_nettype wire

// ### verification/eipu_top_asserts.sv
// concurrent checks on the ports of the external pin interrupt unit
`timescale 1ns/1ps
`default_nettype none

module eipu_top_asserts
  import eipu_pkg::*;
(
  input wire logic i_mclk, // clock
  input wire logic i_rst_n, // reset, active low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb access
  input wire logic i_pwrite, // apb direction
  input wire logic [eipu_pkg::ADDR_W-1:0] i_paddr, // apb address
  input wire logic [31:0] o_prdata, // read data
  input wire logic o_pready, // ready
  input wire logic o_pslverr, // error
  input wire logic i_global_int_en, // global enable
  input wire logic i_sleep, // sleep
  input wire logic i_legacy_mode, // legacy strap
  input wire logic [eipu_pkg::NUM_LINES-1:0] o_irq_req, // requests
  input wire logic [eipu_pkg::ASYNC_LINES-1:0] o_pin_buf_en // buffer enables
);
  // only the five word addresses answer without error
  wire mapped = i_paddr == ADDR_SENSE_LOW || i_paddr == ADDR_SENSE_HIGH || i_paddr == ADDR_ENABLE_MASK ||
                i_paddr == ADDR_PENDING || i_paddr == ADDR_PIN_LEVEL;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_ready; (i_psel && !i_penable) |=> o_pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_ready_acc; o_pready |-> (i_psel && i_penable); endproperty
  a_ready_acc: assert property (p_ready_acc) else $error("ready outside access");
  property p_err; o_pready |-> (o_pslverr == !mapped); endproperty
  a_err: assert property (p_err) else $error("error flag wrong for address");
  property p_width; (o_pready && !i_pwrite) |-> o_prdata[31:8] == 24'h0; endproperty
  a_width: assert property (p_width) else $error("read data wider than a byte");
  property p_legacy; (o_pready && !i_pwrite && i_legacy_mode && i_paddr == ADDR_SENSE_LOW) |-> o_prdata == 32'h0;
  endproperty
  a_legacy: assert property (p_legacy) else $error("hidden register visible");
  property p_gie; (!i_global_int_en)[*2] |-> o_irq_req == 8'h00; endproperty
  a_gie: assert property (p_gie) else $error("request without global enable");
  property p_rise; $rose(|o_irq_req) |-> $past(i_global_int_en); endproperty
  a_rise: assert property (p_rise) else $error("request rose while disabled");
  property p_buf; ($past(o_pin_buf_en) & ~o_pin_buf_en) != 4'h0 |-> $past(i_sleep); endproperty
  a_buf: assert property (p_buf) else $error("buffer off without sleep");
endmodule // eipu_top_asserts

bind eipu_top eipu_top_asserts i_chk (.i_mclk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_prdata,
  .o_pready, .o_pslverr, .i_global_int_en, .i_sleep, .i_legacy_mode, .o_irq_req, .o_pin_buf_en);

`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the external pin interrupt unit
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import eipu_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, gie = 1'b0, sleep = 1'b0;
  logic run = 1'b1, tick = 1'b0, legacy = 1'b0, pready, pslverr, err, wake;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  logic [7:0] pins, pull = 8'h00, ack = 8'h00, irq;
  logic [3:0] buf_en;
  int bad_count = 0, n_tests = 0, seed = 70, wakes = 0;

  // clock and a count of wake pulses
  always #50 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (wake === 1'b1) wakes <= wakes + 1;

  eipu_pins_model i_pins (.i_mclk(i_mclk), .i_pull_low(pull), .o_pins(pins));
  eipu_top i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_ext_request_pins(pins), .i_global_int_en(gie), .i_handler_ack(ack), .i_sleep(sleep),
    .i_io_clk_run(run), .i_wdt_tick(tick), .i_legacy_mode(legacy), .o_irq_req(irq), .o_wake(wake),
    .o_pin_buf_en(buf_en));

  task results;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; the request stands until ready is seen at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    do @(posedge i_mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "read data");
    chk({31'h0, err}, 32'h0, "error flag");
  endtask

  task cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  task pulse_tick;
    tick <= 1'b1;
    @(posedge i_mclk);
    tick <= 1'b0;
    cyc(4);
  endtask

  function logic [31:0] field(input int line, input logic [1:0] code);
    return {30'h0, code} << (2 * (line % SENSE_FIELDS_PER_REG));
  endfunction

  function logic expect_evt(input int line, input logic [1:0] code, input logic fall);
    case (code)
      SENSE_FALL: return fall;
      SENSE_RISE: return !fall;
      SENSE_ANY: return line >= ASYNC_LINES;
      default: return 1'b0;
    endcase
  endfunction

  // one line in one sense code: pull low, then release; flag cleared by ack or by a one
  task edge_case(input int line, input logic [1:0] code);
    logic e;
    apb(1'b1, ADDR_ENABLE_MASK, 32'h0);
    apb(1'b1, line < ASYNC_LINES ? ADDR_SENSE_LOW : ADDR_SENSE_HIGH, field(line, code));
    cyc(8); // a sense change may raise a stray flag; let it land before clearing
    apb(1'b1, ADDR_PENDING, 32'hFF);
    apb(1'b1, ADDR_ENABLE_MASK, 32'h1 << line);
    for (int f = 1; f >= 0; f--) begin
      e = expect_evt(line, code, f[0]);
      pull[line] <= f[0];
      for (int n = 0; n < 12 && irq[line] !== 1'b1; n++) @(posedge i_mclk);
      chk({31'h0, irq[line]}, {31'h0, e}, "request");
      rdc(ADDR_PENDING, {31'h0, e} << line);
      if (e) begin
        if (f == 1) begin
          ack[line] <= 1'b1;
          @(posedge i_mclk);
          ack[line] <= 1'b0;
        end else begin
          apb(1'b1, ADDR_PENDING, 32'h0);
          rdc(ADDR_PENDING, 32'h1 << line);
          apb(1'b1, ADDR_PENDING, 32'h1 << line);
        end
        cyc(3);
        chk({31'h0, irq[line]}, 32'h0, "request cleared");
      end
    end
  endtask

  initial begin
    cyc(6);
    i_rst_n <= 1'b1;
    // reset values, pin image and an unmapped word
    rdc(ADDR_SENSE_LOW, 32'h0);
    rdc(ADDR_SENSE_HIGH, 32'h0);
    rdc(ADDR_ENABLE_MASK, 32'h0);
    rdc(ADDR_PENDING, 32'h0);
    rdc(ADDR_PIN_LEVEL, 32'hFF);
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("test reset done");
    // random values through sense and mask, then the legacy lock
    repeat (4) begin
      v = $random(seed) & 32'hFF;
      apb(1'b1, ADDR_SENSE_HIGH, v);
      rdc(ADDR_SENSE_HIGH, v);
      apb(1'b1, ADDR_ENABLE_MASK, ~v);
      rdc(ADDR_ENABLE_MASK, ~v & 32'hFF);
    end
    apb(1'b1, ADDR_SENSE_LOW, 32'hA5);
    legacy <= 1'b1;
    apb(1'b1, ADDR_SENSE_LOW, 32'h5A);
    rdc(ADDR_SENSE_LOW, 32'h0);
    legacy <= 1'b0;
    rdc(ADDR_SENSE_LOW, 32'hA5);
    $display("test registers done");
    gie <= 1'b1;
    for (int l = 0; l < NUM_LINES; l++)
      for (int c = 1; c < 4; c++)
        edge_case(l, c[1:0]);
    $display("test edges done");
    // level mode on lines 2 and 6, with watchdog sampling for wake
    apb(1'b1, ADDR_ENABLE_MASK, 32'h0);
    apb(1'b1, ADDR_SENSE_LOW, 32'h0);
    apb(1'b1, ADDR_SENSE_HIGH, 32'h0);
    apb(1'b1, ADDR_PENDING, 32'hFF);
    apb(1'b1, ADDR_ENABLE_MASK, 32'h44);
    pull <= 8'h44;
    cyc(8);
    chk({24'h0, irq}, 32'h44, "level request");
    rdc(ADDR_PENDING, 32'h0);
    wakes = 0;
    pulse_tick;
    pulse_tick;
    chk({24'h0, irq}, 32'h44, "level held");
    chk({31'h0, wakes != 0}, 32'h1, "wake");
    pull <= 8'h00;
    cyc(6);
    wakes = 0;
    pulse_tick;
    chk(wakes, 32'h0, "vanished level wake");
    chk({24'h0, irq}, 32'h0, "level released");
    $display("test level done");
    // sleep drops buffers of disabled low lines; halted clock hides high-line edges
    apb(1'b1, ADDR_ENABLE_MASK, 32'h0A);
    sleep <= 1'b1;
    cyc(3);
    chk({28'h0, buf_en}, 32'hA, "buffer enables");
    sleep <= 1'b0;
    apb(1'b1, ADDR_SENSE_HIGH, field(5, SENSE_FALL));
    cyc(8);
    apb(1'b1, ADDR_PENDING, 32'hFF);
    run <= 1'b0;
    pull <= 8'h20;
    cyc(12);
    rdc(ADDR_PENDING, 32'h0);
    run <= 1'b1;
    pull <= 8'h00;
    cyc(6);
    $display("test sleep done");
    results();
  end

  // cut a hang short
  initial begin
    #(20000 * 100);
    bad_count++;
    results();
  end
endmodule // tb_top

`default_nettype wire
